// ### hw/gpc_pkg.sv
// Package with register map, field layout and timing constants of the pin control block.
package gpc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int GPC_NUM_PINS = 2;
  localparam int GPC_ADDR_W = 8;
  localparam int GPC_DATA_W = 32;
  localparam int GPC_REG_W = 8;
  // Printed offsets are not multiples of four, so they are indices and byte address is 4x.
  localparam logic [GPC_ADDR_W-1:0] GPC_IDX_PIN_ONE = 8'h41;
  localparam logic [GPC_ADDR_W-1:0] GPC_IDX_PIN_TWO = 8'h42;
  localparam int GPC_BYTE_SHIFT = 2;
  localparam int GPC_WB_ADR_W = GPC_ADDR_W + GPC_BYTE_SHIFT;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int GPC_BIT_SET = 0;
  localparam int GPC_BIT_LEVEL = 1;
  localparam int GPC_BIT_DIR = 2;
  localparam int GPC_BIT_DEB = 4;
  localparam int GPC_BIT_SLEEP = 7;
  localparam logic [GPC_REG_W-1:0] GPC_WR_MASK = 8'h95;
  localparam logic [GPC_REG_W-1:0] GPC_RESET_DEFAULT = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int GPC_CLK_HZ = 50000000;
  localparam int GPC_DEB_SHORT_US = 94;
  localparam int GPC_DEB_LONG_US = 156;
  localparam int GPC_DEB_SHORT_CYC = GPC_DEB_SHORT_US * (GPC_CLK_HZ / 1000000);
  localparam int GPC_DEB_LONG_CYC = GPC_DEB_LONG_US * (GPC_CLK_HZ / 1000000);
  localparam int GPC_CNT_W = 14;

  typedef enum logic [2:0] {
    GPC_BUS_IDLE = 3'b001,
    GPC_BUS_ACK = 3'b010,
    GPC_BUS_DONE = 3'b100
  } gpc_bus_state_t;

endpackage

// ### hw/gpc_debounce.sv
// Input debounce filter for one pad with a selectable settle time.
`timescale 1ns/1ps
module gpc_debounce
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pad_in,
  input wire logic long_sel,
  input wire logic [GPC_CNT_W-1:0] short_cycles,
  input wire logic [GPC_CNT_W-1:0] long_cycles,
  output logic level
);

  // ----------------------------------------------------------------
  // Settle counter
  // ----------------------------------------------------------------
  logic [GPC_CNT_W-1:0] cnt_r;
  logic [GPC_CNT_W-1:0] cnt_nxt;
  logic level_r;
  wire logic [GPC_CNT_W-1:0] limit = long_sel ? long_cycles : short_cycles;
  wire logic differs = pad_in != level_r;
  wire logic settled = differs && (cnt_r >= limit - 14'h0001);

  // A glitch shorter than the window restarts the count, so the level never follows it.
  always_comb
  begin
    cnt_nxt = '0;
    if (differs && !settled)
    begin
      cnt_nxt = cnt_r + 14'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_r <= '0;
      level_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      if (settled)
      begin
        level_r <= pad_in;
      end
    end
  end

  assign level = level_r;

endmodule

// ### hw/gpc_pin_ctrl.sv
// Control and status registers for two general-purpose pins behind a Wishbone slave.
`timescale 1ns/1ps
// Overview of operation
// - The first pin's register sits at index 0x41 and the second pin's at index 0x42.
// - The second pin's register at 0x42 has the same fields and behaviour as the first.
// - With sleep-force set, the device asleep and the pin an output, the pad is driven low.
// - Debounce-select clear gives a 94 us input debounce and set gives 156 us.
// - With direction clear the pad is an input and is not driven.
// - With direction set the pad is an output handed to the power-up sequencer.
// - The pad-level bit is read-only, shows the debounced pad level and ignores writes.
// - In output mode the output-value bit is driven onto the pad, or seq_level while seq_drive_en is set; sleep-force overrides both.
// - Both control registers return to their defaults on power-on reset.
module gpc_pin_ctrl
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [GPC_WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [GPC_DATA_W-1:0] wb_dat_i,
  output logic [GPC_DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [GPC_REG_W-1:0] otp_default_one,
  input wire logic [GPC_REG_W-1:0] otp_default_two,
  input wire logic sleep_active,
  input wire logic [GPC_NUM_PINS-1:0] seq_drive_en,
  input wire logic [GPC_NUM_PINS-1:0] seq_level,
  input wire logic [GPC_NUM_PINS-1:0] pad_i,
  output logic [GPC_NUM_PINS-1:0] pad_o,
  output logic [GPC_NUM_PINS-1:0] pad_oe,
  output logic [GPC_NUM_PINS-1:0] pad_level,
  output logic [GPC_NUM_PINS-1:0] seq_owned
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [GPC_NUM_PINS-1:0] hit(input logic [GPC_WB_ADR_W-1:0] adr);
    logic [GPC_ADDR_W-1:0] idx;
    idx = adr[GPC_WB_ADR_W-1:GPC_BYTE_SHIFT];
    hit = '0;
    if (adr[GPC_BYTE_SHIFT-1:0] != 2'b00)
    begin
      hit = '0;
    end
    else if (idx == GPC_IDX_PIN_ONE)
    begin
      hit[0] = 1'b1;
    end
    else if (idx == GPC_IDX_PIN_TWO)
    begin
      hit[1] = 1'b1;
    end
  endfunction

  gpc_bus_state_t bus_r;
  gpc_bus_state_t bus_nxt;
  logic [GPC_REG_W-1:0] ctrl_r [GPC_NUM_PINS];
  logic [GPC_DATA_W-1:0] rdata_r;
  logic err_r;
  logic load_pending_r;

  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic [GPC_NUM_PINS-1:0] sel_hit = hit(wb_adr_i);
  wire logic mapped = |sel_hit;
  wire logic take = req && (bus_r == GPC_BUS_IDLE);
  wire logic wr_lane = wb_sel_i[0];

  // ----------------------------------------------------------------
  // Bus sequencing
  // ----------------------------------------------------------------
  // One wait cycle lets the registered read data settle; ack stands for one cycle only.
  always_comb
  begin
    bus_nxt = bus_r;
    case (bus_r)
      GPC_BUS_IDLE:
      begin
        if (req)
        begin
          bus_nxt = GPC_BUS_ACK;
        end
      end
      GPC_BUS_ACK:
      begin
        bus_nxt = GPC_BUS_DONE;
      end
      GPC_BUS_DONE:
      begin
        if (!req)
        begin
          bus_nxt = GPC_BUS_IDLE;
        end
      end
      default:
      begin
        bus_nxt = GPC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bus_r <= GPC_BUS_IDLE;
      err_r <= 1'b0;
    end
    else
    begin
      bus_r <= bus_nxt;
      if (take)
      begin
        err_r <= !mapped;
      end
    end
  end

  assign wb_ack_o = (bus_r == GPC_BUS_ACK) && !err_r;
  assign wb_err_o = (bus_r == GPC_BUS_ACK) && err_r;
  assign wb_dat_o = rdata_r;

  // ----------------------------------------------------------------
  // Per-pin registers and pad logic
  // ----------------------------------------------------------------
  // Reset is synchronous, so the default word from one-time memory is loaded on the
  // first edge after release rather than captured in the reset branch.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      load_pending_r <= 1'b1;
    end
    else
    begin
      load_pending_r <= 1'b0;
    end
  end

  wire logic [GPC_REG_W-1:0] otp_word [GPC_NUM_PINS];
  assign otp_word[0] = otp_default_one;
  assign otp_word[1] = otp_default_two;

  logic [GPC_REG_W-1:0] rd_word [GPC_NUM_PINS];

  genvar g;
  generate
    for (g = 0; g < GPC_NUM_PINS; g = g + 1)
    begin : pin
      wire logic wr_hit = take && wb_we_i && wr_lane && sel_hit[g];
      wire logic [GPC_REG_W-1:0] wr_val = wb_dat_i[GPC_REG_W-1:0] & GPC_WR_MASK;
      wire logic dir_out = ctrl_r[g][GPC_BIT_DIR];
      wire logic sleep_low = ctrl_r[g][GPC_BIT_SLEEP] && sleep_active && dir_out;
      wire logic drive_val = seq_drive_en[g] ? seq_level[g] : ctrl_r[g][GPC_BIT_SET];
      logic deb_level;
      logic pad_o_r;

      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          ctrl_r[g] <= GPC_RESET_DEFAULT;
        end
        else if (load_pending_r)
        begin
          ctrl_r[g] <= otp_word[g] & GPC_WR_MASK;
        end
        else if (wr_hit)
        begin
          ctrl_r[g] <= wr_val;
        end
      end

      gpc_debounce u_deb (
        .clk(clk),
        .reset(reset),
        .pad_in(pad_i[g]),
        .long_sel(ctrl_r[g][GPC_BIT_DEB]),
        .short_cycles(GPC_CNT_W'(GPC_DEB_SHORT_CYC)),
        .long_cycles(GPC_CNT_W'(GPC_DEB_LONG_CYC)),
        .level(deb_level)
      );

      // Sleep forcing overrides the sequencer too, since sleep is the deeper power state.
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          pad_o_r <= 1'b0;
        end
        else
        begin
          pad_o_r <= sleep_low ? 1'b0 : drive_val;
        end
      end

      assign pad_o[g] = pad_o_r;
      assign pad_oe[g] = dir_out;
      assign seq_owned[g] = dir_out;
      assign pad_level[g] = deb_level;
      assign rd_word[g] = (ctrl_r[g] & GPC_WR_MASK) | (8'(deb_level) << GPC_BIT_LEVEL);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire logic [GPC_REG_W-1:0] rd_sel = sel_hit[0] ? rd_word[0] : (sel_hit[1] ? rd_word[1] : '0);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_r <= '0;
    end
    else if (take)
    begin
      rdata_r <= {{(GPC_DATA_W-GPC_REG_W){1'b0}}, rd_sel};
    end
  end

endmodule

// ### bench/gpc_pad_model.sv
// Model of the outside circuitry wired to the two pads.
`timescale 1ns/1ps
module gpc_pad_model (
  input logic [1:0] pad_o,
  input logic [1:0] pad_oe,
  input logic [1:0] ext,
  output logic [1:0] pad_i
);
  // A pad shows the pin's own drive while enabled, else the outside level.
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext);
endmodule

// ### bench/gpc_pin_ctrl_chk.sv
// Checker for bus timing and pin behaviour of the pin control block.
`timescale 1ns/1ps
module gpc_pin_ctrl_chk (
  input logic clk,
  input logic reset,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [9:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic wb_err_o,
  input logic [7:0] otp_default_one,
  input logic [7:0] otp_default_two,
  input logic sleep_active,
  input logic [1:0] seq_drive_en,
  input logic [1:0] pad_i,
  input logic [1:0] pad_o,
  input logic [1:0] pad_oe,
  input logic [1:0] pad_level
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire hit = wb_adr_i == 10'h104 || wb_adr_i == 10'h108;
  a_map_ack: assert property (take && hit |=> wb_ack_o && !wb_err_o)
    else $error("no ack");
  a_unmap_err: assert property (take && !hit |=> wb_err_o && !wb_ack_o)
    else $error("no err");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  a_reserved_bit_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[6:5] == 2'h0 && !wb_dat_o[3])
    else $error("reserved set");
  a_set_drive: assert property (take && wb_we_i && wb_adr_i == 10'h104 && wb_sel_i[0] && wb_dat_i[2] && !sleep_active && !seq_drive_en[0] |-> ##2 pad_o[0] == $past(wb_dat_i[0], 2) && pad_oe[0])
    else $error("bad drive");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !wb_ack_o && !wb_err_o && pad_oe == 2'h0)
    else $error("busy in reset");
  a_otp_load: assert property ($fell(reset) |-> ##1 pad_oe == {otp_default_two[2], otp_default_one[2]})
    else $error("bad default");
  a_deb_settled: assert property ($changed(pad_level[0]) |-> pad_level[0] == $past(pad_i[0], 2))
    else $error("bad level");
  c_write: cover property (take && wb_we_i && hit);
  c_err: cover property (wb_err_o);
  c_sleep: cover property (sleep_active && pad_oe[0] && !pad_o[0]);
endmodule

// ### bench/gpc_pin_ctrl_bench.sv
// Self-checking bench for the pin control block.
`timescale 1ns/1ps
module gpc_pin_ctrl_bench
  import gpc_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic sleep_active = 1'b0, wb_ack_o, wb_err_o;
  logic [9:0] wb_adr_i = 10'h0, a;
  logic [9:0] bad[4] = '{10'h100, 10'h10c, 10'h105, 10'h3fc};
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [7:0] otp_default_one = 8'hff, otp_default_two = 8'h7f, d;
  logic [1:0] seq_drive_en = 2'h0, seq_level = 2'h0, ext = 2'h0;
  logic [1:0] pad_i, pad_o, pad_oe, pad_level, seq_owned;
  logic [15:0] q[$], x;
  int n_fail = 0, tests_run = 0, n;
  integer seed = 32'h59769cd5;
  always #10 clk = ~clk;
  gpc_pin_ctrl gpc_pin_ctrl_inst (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .otp_default_one, .otp_default_two,
    .sleep_active, .seq_drive_en, .seq_level, .pad_i, .pad_o, .pad_oe, .pad_level, .seq_owned);
  gpc_pad_model gpc_pad_model_inst (.pad_o, .pad_oe, .ext, .pad_i);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // The master holds every signal until it sees the answer.
  task wb(input logic w, input logic [9:0] ad, input logic [7:0] v, input logic [3:0] s);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= {24'h0, v};
    wb_sel_i <= s;
    do @(posedge clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [9:0] ad, input logic [7:0] m, e);
    q.push_back({m, e});
    wb(1'b0, ad, 8'h0, 4'hf);
  endtask
  // Level changes only after the pad has been steady for the whole filter time.
  task deb(input logic v, input int lo, input logic [7:0] r);
    ext[0] <= v;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pad_level[0] !== v);
    chk(n >= lo && n <= lo + 3, 1'b1);
    rd(10'h104, 8'hff, r | {6'h0, v, 1'b0});
  endtask
  always @(posedge clk)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0)
    begin
      x = q.pop_front();
      chk(wb_dat_o[7:0] & x[15:8], x[7:0]);
    end
  initial
  begin
    #1000000;
    n_fail++;
    test_done;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pad_oe, 2'b11);
    rd(10'h104, 8'hfd, 8'h95);
    rd(10'h108, 8'hfd, 8'h15);
    $display("done reset");
    for (int i = 0; i < 8; i++)
    begin
      d = $random(seed);
      a = i[0] ? 10'h108 : 10'h104;
      wb(1'b1, a, d, 4'h1);
      #1;
      chk(pad_oe[i[0]], d[2]);
      if (d[2])
        chk(pad_o[i[0]], d[0]);
      rd(a, 8'hfd, d & 8'h95);
    end
    wb(1'b1, 10'h104, 8'hff, 4'h1);
    wb(1'b1, 10'h104, 8'h00, 4'he);
    rd(10'h104, 8'hfd, 8'h95);
    foreach (bad[k])
    begin
      wb(1'b1, bad[k], 8'h00, 4'h1);
      chk(wb_err_o, 1'b1);
    end
    rd(10'h104, 8'hfd, 8'h95);
    $display("done map");
    wb(1'b1, 10'h104, 8'h85, 4'h1);
    sleep_active <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pad_o[0], 1'b0);
    wb(1'b1, 10'h104, 8'h05, 4'h1);
    #1;
    chk(pad_o[0], 1'b1);
    sleep_active <= 1'b0;
    wb(1'b1, 10'h108, 8'h04, 4'h1);
    seq_drive_en <= 2'b10;
    seq_level <= 2'b10;
    repeat (3) @(posedge clk);
    chk(pad_o[1], 1'b1);
    chk(seq_owned[1], 1'b1);
    seq_drive_en <= 2'b00;
    $display("done drive");
    wb(1'b1, 10'h104, 8'h00, 4'h1);
    #1;
    chk(pad_oe[0], 1'b0);
    repeat (8000) @(posedge clk);
    deb(1'b1, 4700, 8'h00);
    wb(1'b1, 10'h104, 8'h10, 4'h1);
    deb(1'b0, 7800, 8'h10);
    $display("done debounce");
    test_done;
  end
endmodule
bind gpc_pin_ctrl gpc_pin_ctrl_chk gpc_pin_ctrl_chk_inst (.clk, .reset, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .otp_default_one,
  .otp_default_two, .sleep_active, .seq_drive_en, .pad_i, .pad_o, .pad_oe, .pad_level);
